//--- hdl/pin_select_defs.svh
// constants for the pin function select block
`ifndef PIN_SELECT_DEFS_SVH
`define PIN_SELECT_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (command codes)
// ----------------------------------------------------------------
`define OUTPUT_DISABLE_OFS 8'h02
`define REQUEST_PIN_CFG_OFS 8'h05

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DIS_BCLK0_BIT 0
`define DIS_BCLK1_BIT 1
`define REQ_A_EN_BIT 7
`define REQ_A_SEL_BIT 6
`define REQ_B_EN_BIT 5
`define REQ_B_SEL_BIT 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OUTPUT_DISABLE_RST 8'h00
`define REQUEST_PIN_CFG_RST 8'h00

// ----------------------------------------------------------------
// serial slave address (arbitrary value)
// ----------------------------------------------------------------
`define SMB_DEV_ADDR 7'h2a

`endif

//--- hdl/pin_select_pkg.sv
// types shared by the pin function select design
package pin_select_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] bit_cnt_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_CMD = 4'h2,
    ST_CMD_ACK = 4'h6,
    ST_WDATA = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA = 4'h4,
    ST_RDATA_ACK = 4'hc
  } smb_state_e;
endpackage

//--- hdl/reg_access_if.sv
// register access channel between the serial slave and the core
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
  import pin_select_pkg::*;
  logic wr;
  byte_t addr;
  byte_t wdata;
  byte_t rdata;
  modport slave_side (output wr, output addr, output wdata, input rdata);
  modport core_side (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

//--- hdl/smb_byte_slave.sv
// serial management bus slave: byte write and byte read
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_defs.svh"
module smb_byte_slave (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_smb_clk,
  input wire logic i_smb_data,
  output logic o_smb_data,
  output logic o_smb_data_oe_n,
  reg_access_if.slave_side bus
);
  import pin_select_pkg::*;

  logic [1:0] clk_s1, dat_s1;
  logic clk_s2, dat_s2, clk_d, dat_d;
  smb_state_e state, next_state;
  bit_cnt_t cnt, next_cnt;
  byte_t shreg, next_shreg, cmd, next_cmd;
  logic rd, next_rd, wr, next_wr, oe_n, next_oe_n;
  logic rise, fall, start, stop;

  // ----------------------------------------------------------------
  // pin synchronisers; edges seen only on the second stage
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    clk_s1 <= {clk_s1[0], i_smb_clk};
    dat_s1 <= {dat_s1[0], i_smb_data};
    clk_d <= clk_s2;
    dat_d <= dat_s2;
  end
  assign clk_s2 = clk_s1[1];
  assign dat_s2 = dat_s1[1];
  assign rise = clk_s2 & ~clk_d;
  assign fall = ~clk_s2 & clk_d;
  assign start = clk_s2 & clk_d & dat_d & ~dat_s2;
  assign stop = clk_s2 & clk_d & ~dat_d & dat_s2;

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_cmd = cmd;
    next_rd = rd;
    next_wr = 1'b0;
    if (start) begin
      next_state = ST_ADDR;
      next_cnt = 4'h0;
    end else if (stop) begin
      next_state = ST_IDLE;
    end else if (rise && (state == ST_ADDR || state == ST_CMD ||
                          state == ST_WDATA)) begin
      next_shreg = {shreg[6:0], dat_s2};
      next_cnt = cnt + 4'h1;
    end else if (fall) begin
      case (state)
        ST_ADDR: begin
          if (cnt == 4'h8) begin
            next_rd = shreg[0];
            next_state = (shreg[7:1] == `SMB_DEV_ADDR) ? ST_ADDR_ACK
                                                        : ST_IDLE;
          end
        end
        ST_ADDR_ACK: begin
          next_cnt = 4'h0;
          if (rd) begin
            next_shreg = bus.rdata;
            next_state = ST_RDATA;
          end else begin
            next_state = ST_CMD;
          end
        end
        ST_CMD: begin
          if (cnt == 4'h8) begin
            next_cmd = shreg;
            next_state = ST_CMD_ACK;
          end
        end
        ST_CMD_ACK: begin
          next_cnt = 4'h0;
          next_state = ST_WDATA;
        end
        ST_WDATA: begin
          if (cnt == 4'h8) begin
            next_wr = 1'b1;
            next_state = ST_WDATA_ACK;
          end
        end
        ST_WDATA_ACK: begin
          next_cnt = 4'h0;
          next_state = ST_WDATA;
        end
        ST_RDATA: begin
          next_shreg = {shreg[6:0], 1'b1};
          next_cnt = cnt + 4'h1;
          if (cnt == 4'h7) begin
            next_state = ST_RDATA_ACK;
          end
        end
        ST_RDATA_ACK: next_state = ST_IDLE;
        default: next_state = ST_IDLE;
      endcase
    end
    // pull the line low only for acks and zero read bits
    next_oe_n = ~(next_state == ST_ADDR_ACK || next_state == ST_CMD_ACK ||
                  next_state == ST_WDATA_ACK ||
                  (next_state == ST_RDATA && ~next_shreg[7]));
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      cmd <= 8'h00;
      rd <= 1'b0;
      wr <= 1'b0;
      oe_n <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      cmd <= next_cmd;
      rd <= next_rd;
      wr <= next_wr;
      oe_n <= next_oe_n;
    end
  end

  assign o_smb_data = 1'b0;
  assign o_smb_data_oe_n = oe_n;
  // write data is the finished shift register, held until the next byte
  assign bus.wr = wr;
  assign bus.addr = cmd;
  assign bus.wdata = shreg;
endmodule
`default_nettype wire

//--- hdl/clock_pin_function_select.sv
// pin function select core of the clock generator
//
// How it works
// - first shared pin comes up after reset as bus clock output 0.
// - config bit 7 of byte 5 turns pin 0 into request input A.
// - bit 6 of byte 5 picks pair 0 or pair 2 for request A.
// - config bit 5 of byte 5 turns pin 1 into request input B.
// - bit 4 of byte 5 picks pair 1 or pair 4 for request B.
// - a disabled bus clock output releases its pin to high impedance.
// - trusted strap latched at reset; 0 allows overclocking, 1 forbids it.
// - after latching, the trusted strap pin drives bus clock 2.
// - pair five strap: 0 gives stop inputs, 1 gives reference pair 5.
// - debug strap: 0 gives reference pair 8, 1 gives debug clock pair.
// - free running bus clock ignores the bus clock stop input.
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_defs.svh"
module clock_pin_function_select (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_smb_clk,
  input wire logic i_smb_data,
  output logic o_smb_data,
  output logic o_smb_data_oe_n,
  input wire logic [4:0] i_bus_clock_pin,
  output logic [4:0] o_bus_clock,
  output logic [4:0] o_bus_clock_oe_n,
  input wire logic i_free_clock_pin,
  output logic o_free_clock,
  output logic o_free_clock_oe_n,
  input wire logic i_stop_bus_n,
  input wire logic i_stop_cpu_n,
  output logic o_ref_pair_5_oe_n,
  output logic o_ref_pair_0_run,
  output logic o_ref_pair_1_run,
  output logic o_ref_pair_2_run,
  output logic o_ref_pair_4_run,
  output logic o_ref_pair_5_run,
  output logic o_ref_pair_8_run,
  output logic o_debug_pair_run,
  output logic o_cpu_stopped,
  output logic o_overclock_allowed
);
  import pin_select_pkg::*;

  localparam int N_SYNC = 7;
  localparam int SY_REQ_A = 0;
  localparam int SY_REQ_B = 1;
  localparam int SY_TRUST = 2;
  localparam int SY_PAIR5 = 3;
  localparam int SY_DEBUG = 4;
  localparam int SY_STOPB = 5;
  localparam int SY_STOPC = 6;

  reg_access_if rbus ();

  logic [N_SYNC-1:0] sync1, sync2, raw_in;
  byte_t out_dis, next_out_dis, req_cfg, next_req_cfg;
  logic trusted, next_trusted, pair5, next_pair5, debug, next_debug;
  logic phase, next_phase;
  logic [4:0] bclk, next_bclk, bclk_oe_n, next_bclk_oe_n;
  logic fclk, next_fclk, fclk_oe_n, next_fclk_oe_n;
  logic [6:0] run, next_run;
  logic cpu_stop, next_cpu_stop, p5_oe_n, next_p5_oe_n;
  logic mode_a, mode_b, idle_a, idle_b, bus_stop;

  function automatic logic hit(input byte_t a, input byte_t ofs);
    return a == ofs;
  endfunction

  smb_byte_slave u_smb (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_smb_clk(i_smb_clk),
    .i_smb_data(i_smb_data),
    .o_smb_data(o_smb_data),
    .o_smb_data_oe_n(o_smb_data_oe_n),
    .bus(rbus.slave_side)
  );

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  assign raw_in = {i_stop_cpu_n, i_stop_bus_n, i_free_clock_pin,
                   i_bus_clock_pin[4], i_bus_clock_pin[2],
                   i_bus_clock_pin[1], i_bus_clock_pin[0]};
  always_ff @(posedge i_clk_sys) begin
    sync1 <= raw_in;
    sync2 <= sync1;
  end

  // ----------------------------------------------------------------
  // registers and straps
  // ----------------------------------------------------------------
  assign rbus.rdata = hit(rbus.addr, `OUTPUT_DISABLE_OFS) ? out_dis :
                      hit(rbus.addr, `REQUEST_PIN_CFG_OFS) ? req_cfg : 8'h00;

  always_comb begin
    next_out_dis = out_dis;
    next_req_cfg = req_cfg;
    if (rbus.wr && hit(rbus.addr, `OUTPUT_DISABLE_OFS)) begin
      next_out_dis = rbus.wdata;
    end
    if (rbus.wr && hit(rbus.addr, `REQUEST_PIN_CFG_OFS)) begin
      next_req_cfg = rbus.wdata;
    end
    // straps follow their pins while reset is held and freeze at release
    next_trusted = i_reset ? sync2[SY_TRUST] : trusted;
    next_pair5 = i_reset ? sync2[SY_PAIR5] : pair5;
    next_debug = i_reset ? sync2[SY_DEBUG] : debug;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      out_dis <= `OUTPUT_DISABLE_RST;
      req_cfg <= `REQUEST_PIN_CFG_RST;
    end else begin
      out_dis <= next_out_dis;
      req_cfg <= next_req_cfg;
    end
    trusted <= next_trusted;
    pair5 <= next_pair5;
    debug <= next_debug;
  end

  // ----------------------------------------------------------------
  // pin roles and clock gating
  // ----------------------------------------------------------------
  assign mode_a = req_cfg[`REQ_A_EN_BIT];
  assign mode_b = req_cfg[`REQ_B_EN_BIT];
  // a request that is high asks for the selected pair to stop
  assign idle_a = mode_a & sync2[SY_REQ_A];
  assign idle_b = mode_b & sync2[SY_REQ_B];
  // stop inputs exist only when the shared pins are not pair 5
  assign bus_stop = ~pair5 & ~sync2[SY_STOPB];

  always_comb begin
    next_phase = ~phase;
    for (int i = 0; i < 5; i++) begin
      next_bclk[i] = next_phase & ~bus_stop;
      // a disabled output floats so the pin can serve as an input
      next_bclk_oe_n[i] = out_dis[i];
    end
    // request mode releases the pin even if the host has not disabled the output
    next_bclk_oe_n[0] = out_dis[`DIS_BCLK0_BIT] | mode_a;
    next_bclk_oe_n[1] = out_dis[`DIS_BCLK1_BIT] | mode_b;
    // strap pins stay released while the strap is being sampled
    next_bclk_oe_n[2] = out_dis[2] | i_reset;
    next_bclk_oe_n[4] = out_dis[4] | i_reset;
    next_fclk = next_phase;
    next_fclk_oe_n = i_reset;
    next_run[0] = ~(idle_a & ~req_cfg[`REQ_A_SEL_BIT]);
    next_run[2] = ~(idle_a & req_cfg[`REQ_A_SEL_BIT]);
    next_run[1] = ~(idle_b & ~req_cfg[`REQ_B_SEL_BIT]);
    next_run[3] = ~(idle_b & req_cfg[`REQ_B_SEL_BIT]);
    next_run[4] = pair5;
    next_run[5] = ~debug;
    next_run[6] = debug;
    next_p5_oe_n = ~pair5 | i_reset;
    next_cpu_stop = ~pair5 & ~sync2[SY_STOPC];
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      phase <= 1'b0;
      bclk <= 5'h00;
      fclk <= 1'b0;
      run <= 7'h00;
      cpu_stop <= 1'b0;
    end else begin
      phase <= next_phase;
      bclk <= next_bclk;
      fclk <= next_fclk;
      run <= next_run;
      cpu_stop <= next_cpu_stop;
    end
    bclk_oe_n <= next_bclk_oe_n;
    fclk_oe_n <= next_fclk_oe_n;
    p5_oe_n <= next_p5_oe_n;
  end

  assign o_bus_clock = bclk;
  assign o_bus_clock_oe_n = bclk_oe_n;
  assign o_free_clock = fclk;
  assign o_free_clock_oe_n = fclk_oe_n;
  assign o_ref_pair_0_run = run[0];
  assign o_ref_pair_1_run = run[1];
  assign o_ref_pair_2_run = run[2];
  assign o_ref_pair_4_run = run[3];
  assign o_ref_pair_5_run = run[4];
  assign o_ref_pair_8_run = run[5];
  assign o_debug_pair_run = run[6];
  assign o_ref_pair_5_oe_n = p5_oe_n;
  assign o_cpu_stopped = cpu_stop;
  assign o_overclock_allowed = ~trusted;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_pin0_default: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (!req_cfg[7] && !out_dis[0]) |=> !o_bus_clock_oe_n[0])
    else $error("bus clock 0 not driven in default role");
  chk_pin1_request: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    req_cfg[5] |=> o_bus_clock_oe_n[1])
    else $error("pin 1 driven while a request input");
  chk_disable_hiz: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (out_dis[4:0] != 5'h00)
      |=> (o_bus_clock_oe_n & $past(out_dis[4:0])) == $past(out_dis[4:0]))
    else $error("disabled bus clock still drives");
  chk_req_a_gate: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (req_cfg[7] && req_cfg[6] && sync2[SY_REQ_A])
      |=> !o_ref_pair_2_run && o_ref_pair_0_run)
    else $error("request A gated the wrong pair");
  chk_req_b_gate: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (req_cfg[5] && !req_cfg[4] && sync2[SY_REQ_B])
      |=> !o_ref_pair_1_run && o_ref_pair_4_run)
    else $error("request B gated the wrong pair");
  chk_trust_hold: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    !$past(i_reset) |-> $stable(o_overclock_allowed))
    else $error("trusted mode changed after latching");
  chk_trust_pin_out: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (!out_dis[2] && !i_reset) |=> !o_bus_clock_oe_n[2])
    else $error("trusted strap pin not driving after latch");
  chk_stop_bus: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (!pair5 && !sync2[SY_STOPB])[*2] |-> o_bus_clock == 5'h00)
    else $error("bus clocks run while stopped");
  chk_free_toggle: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    !$past(i_reset) |=> o_free_clock != $past(o_free_clock))
    else $error("free running clock stalled");
  chk_debug_excl: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    !$past(i_reset) |-> o_debug_pair_run != o_ref_pair_8_run)
    else $error("pair 8 and debug pair both or neither");
endmodule
`default_nettype wire

//--- dv/board_model.sv
// board side of the block: pull-up on data, straps and request drivers
`timescale 1ns/1ps
`default_nettype none
module board_model (
  input wire logic i_scl_host,
  input wire logic i_sda_host_low,
  input wire logic i_smb_data_oe_n,
  input wire logic [2:0] i_strap,
  input wire logic [1:0] i_req_n,
  input wire logic [4:0] i_bus_clock,
  input wire logic [4:0] i_bus_clock_oe_n,
  input wire logic i_free_clock,
  input wire logic i_free_clock_oe_n,
  output logic o_smb_clk,
  output logic o_smb_data,
  output logic [4:0] o_pin,
  output logic o_free_pin
);
  logic [4:0] board;
  // ----------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------
  assign o_smb_clk = i_scl_host;
  // pulled up: low only while some party pulls it
  assign o_smb_data = ~(i_sda_host_low | ~i_smb_data_oe_n);
  // pin 3 has no board driver; a released pin shows the inverse level
  assign board = {i_strap[1], ~i_bus_clock[3], i_strap[0],
                  i_req_n};
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      o_pin[k] = i_bus_clock_oe_n[k] ? board[k] : i_bus_clock[k];
    end
  end
  assign o_free_pin = i_free_clock_oe_n ? i_strap[2] : i_free_clock;
endmodule
`default_nettype wire

//--- dv/clock_pin_function_select_tb.sv
// self-checking bench for the pin function select block
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_defs.svh"
module clock_pin_function_select_tb;
  import pin_select_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl = 1'b1;
  logic sda_low = 1'b0;
  // {debug, pair five, trusted}
  logic [2:0] strap = 3'b001;
  logic [1:0] req_n = 2'b11;
  logic stop_bus_n = 1'b1;
  logic stop_cpu_n = 1'b1;
  logic smb_clk, smb_data, o_sda, o_sda_oe_n;
  logic [4:0] pin, bclk, bclk_oe_n;
  logic fpin, fclk, fclk_oe_n;
  logic r5_oe_n, r0, r1, r2, r4, r5, r8, dbg, cpu_stop, ovc;
  logic [3:0] runs;
  int mismatches = 0;
  int n_tests = 0;
  assign runs = {r4, r2, r1, r0};
  initial begin
    forever #10 clk = ~clk;
  end
  clock_pin_function_select uut (
    .i_clk_sys(clk), .i_reset(rst), .i_smb_clk(smb_clk),
    .i_smb_data(smb_data), .o_smb_data(o_sda),
    .o_smb_data_oe_n(o_sda_oe_n), .i_bus_clock_pin(pin),
    .o_bus_clock(bclk), .o_bus_clock_oe_n(bclk_oe_n),
    .i_free_clock_pin(fpin), .o_free_clock(fclk),
    .o_free_clock_oe_n(fclk_oe_n), .i_stop_bus_n(stop_bus_n),
    .i_stop_cpu_n(stop_cpu_n), .o_ref_pair_5_oe_n(r5_oe_n),
    .o_ref_pair_0_run(r0), .o_ref_pair_1_run(r1),
    .o_ref_pair_2_run(r2), .o_ref_pair_4_run(r4),
    .o_ref_pair_5_run(r5), .o_ref_pair_8_run(r8),
    .o_debug_pair_run(dbg), .o_cpu_stopped(cpu_stop),
    .o_overclock_allowed(ovc)
  );
  board_model far_side (
    .i_scl_host(scl), .i_sda_host_low(sda_low),
    .i_smb_data_oe_n(o_sda_oe_n), .i_strap(strap), .i_req_n(req_n),
    .i_bus_clock(bclk), .i_bus_clock_oe_n(bclk_oe_n),
    .i_free_clock(fclk), .i_free_clock_oe_n(fclk_oe_n),
    .o_smb_clk(smb_clk), .o_smb_data(smb_data), .o_pin(pin),
    .o_free_pin(fpin)
  );
  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input byte_t exp, input byte_t got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    conclude();
  end
  // ----------------------------------------------------------------
  // serial bus host, 8 clocks per phase keeps SCL low long enough
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic send_bit(input logic b, output logic r);
    tick(4);
    sda_low <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(8);
    r = smb_data;
    scl <= 1'b0;
  endtask
  task automatic send_byte(input byte_t v, output logic ack);
    logic r;
    for (int k = 7; k >= 0; k--) begin
      send_bit(v[k], r);
    end
    send_bit(1'b1, ack);
  endtask
  // works from idle and as a repeated start after an ack
  task automatic start_cond();
    tick(4);
    sda_low <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask
  task automatic stop_cond();
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(8);
  endtask
  task automatic reg_write(input byte_t cmd, input byte_t d);
    logic a;
    logic c;
    start_cond();
    send_byte({`SMB_DEV_ADDR, 1'b0}, a);
    send_byte(cmd, c);
    send_byte(d, c);
    stop_cond();
    chk("write address ack", 8'h00, {7'h00, a});
  endtask
  task automatic read_chk(input string what, input byte_t cmd,
                          input byte_t exp);
    logic c;
    byte_t d;
    start_cond();
    send_byte({`SMB_DEV_ADDR, 1'b0}, c);
    send_byte(cmd, c);
    start_cond();
    send_byte({`SMB_DEV_ADDR, 1'b1}, c);
    for (int k = 7; k >= 0; k--) begin
      send_bit(1'b1, c);
      d[k] = c;
    end
    send_bit(1'b1, c);
    stop_cond();
    chk(what, exp, d);
  endtask
  task automatic do_reset(input logic [2:0] s);
    rst <= 1'b1;
    strap <= s;
    tick(4);
    chk("straps released in reset", 8'h0f,
        {4'h0, r5_oe_n, fclk_oe_n, bclk_oe_n[4], bclk_oe_n[2]});
    tick(1);
    rst <= 1'b0;
    tick(3);
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  logic f0;
  byte_t cfg [4] = '{8'h80, 8'hc0, 8'h20, 8'h30};
  int sel [4] = '{0, 2, 1, 3};
  initial begin
    tick(1);
    do_reset(3'b001);
    chk("overclock allowed", 8'h00, {7'h00, ovc});
    chk("bus clock drive", 8'h00, {3'h0, bclk_oe_n});
    chk("pair five drive", 8'h01, {7'h00, r5_oe_n});
    chk("pair five run", 8'h00, {7'h00, r5});
    chk("pair eight run", 8'h01, {7'h00, r8});
    chk("debug pair run", 8'h00, {7'h00, dbg});
    chk("free clock drive", 8'h00, {6'h00, o_sda, fclk_oe_n});
    read_chk("disable reset value", `OUTPUT_DISABLE_OFS, 8'h00);
    read_chk("request reset value", `REQUEST_PIN_CFG_OFS, 8'h00);
    stop_bus_n <= 1'b0;
    stop_cpu_n <= 1'b0;
    tick(6);
    f0 = fclk;
    tick(1);
    chk("free clock toggles", {7'h00, !f0}, {7'h00, fclk});
    chk("bus clocks stopped", 8'h00, {3'h0, bclk});
    chk("cpu stopped", 8'h01, {7'h00, cpu_stop});
    $display("test strap set one done");
    do_reset(3'b110);
    chk("overclock allowed", 8'h01, {7'h00, ovc});
    chk("pair five drive", 8'h00, {7'h00, r5_oe_n});
    chk("pair five run", 8'h01, {7'h00, r5});
    chk("pair eight run", 8'h00, {7'h00, r8});
    chk("debug pair run", 8'h01, {7'h00, dbg});
    chk("stop ignored", 8'h00, {7'h00, cpu_stop});
    f0 = bclk[0];
    tick(1);
    chk("bus clock 0 toggles", {7'h00, !f0}, {7'h00, bclk[0]});
    stop_bus_n <= 1'b1;
    stop_cpu_n <= 1'b1;
    $display("test strap set two done");
    reg_write(`OUTPUT_DISABLE_OFS, 8'h03);
    tick(2);
    chk("disabled pins released", 8'h03, {3'h0, bclk_oe_n});
    read_chk("disable readback", `OUTPUT_DISABLE_OFS, 8'h03);
    req_n <= 2'b11;
    tick(5);
    chk("pair 0 runs by default", 8'h01, {7'h00, r0});
    for (int k = 0; k < 4; k++) begin
      reg_write(`REQUEST_PIN_CFG_OFS, cfg[k]);
      read_chk("request readback", `REQUEST_PIN_CFG_OFS, cfg[k]);
      for (int lvl = 0; lvl < 2; lvl++) begin
        req_n <= (lvl == 1) ? 2'b11 : 2'b00;
        tick(5);
        chk("gated pair run", {7'h00, lvl == 0},
            {7'h00, runs[sel[k]]});
      end
    end
    $display("test request modes done");
    reg_write(8'h07, 8'h5a);
    read_chk("unmapped command", 8'h07, 8'h00);
    start_cond();
    send_byte({7'h15, 1'b0}, f0);
    stop_cond();
    chk("foreign address ack", 8'h01, {7'h00, f0});
    $display("test refusals done");
    conclude();
  end
endmodule
`default_nettype wire
